// [common/adcc_pkg.sv]
// Purpose: shared constants for the async dma context control bank
// Assumes: axi4-lite register access, 32-bit data, one clock
// Notes: all offsets are byte addresses
// Overview of operation
// (R1) Reserved control bits 31-16, 14-13 and 9-8 always read as zero.
// (R2) Software sets run to let a context work and clears it to halt the context.
// (R3) Only a hardware or software reset changes run besides software writes.
// (R4) Software sets wake to make the context continue, and the engine is told of it; here ctx_wake shows it to the engine only while run is set.
// (R5) Each descriptor fetch for a context clears its wake bit; here a software set of wake in the same cycle wins over the fetch.
// (R6) A fatal error in a context sets its dead flag.
// (R7) Dead stays set until software clears run, and that clear also clears dead.
// (R8) The active flag is high while the context is processing descriptors.
// (R9) The speed field holds 0 for 100, 1 for 200 and 2 for 400 Mbit/s.
// (R10) The speed field means something only for receive contexts.
// (R11) The event field holds the returned acknowledge or an internal error code.
// (R12) Each context has a set address and a clear address four bytes above it.
// (R13) The receive request context has its own set and clear offsets.
// (R14) Setting run starts a fetch from that context's command pointer.
// (R15) Ones written at set set bits, ones at clear clear them, reads show state; clear writes here clear only run, never wake.
// (R16) After reset run, wake, dead and active read zero.
package adcc_pkg;
   localparam int ADDR_W = 9;
   localparam int NUM_CTX = 4;
   localparam int IRQ_W = 8;
   localparam logic [ADDR_W-1:0] TXREQ_SET_OFS = 9'h180;
   localparam logic [ADDR_W-1:0] TXREQ_CLR_OFS = 9'h184;
   localparam logic [ADDR_W-1:0] TXRSP_SET_OFS = 9'h1a0;
   localparam logic [ADDR_W-1:0] TXRSP_CLR_OFS = 9'h1a4;
   localparam logic [ADDR_W-1:0] RXREQ_SET_OFS = 9'h1c0;
   localparam logic [ADDR_W-1:0] RXREQ_CLR_OFS = 9'h1c4;
   localparam logic [ADDR_W-1:0] RXRSP_SET_OFS = 9'h1e0;
   localparam logic [ADDR_W-1:0] RXRSP_CLR_OFS = 9'h1e4;
   localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 9'h000;
   localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 9'h004;
   localparam int RUN_BIT = 15;
   localparam int WAKE_BIT = 12;
   localparam int DEAD_BIT = 11;
   localparam int ACTIVE_BIT = 10;
   localparam int SPD_LSB = 5;
   localparam int SPD_W = 3;
   localparam int EVT_LSB = 0;
   localparam int EVT_W = 5;
   localparam logic [SPD_W-1:0] SPD_100 = 3'h0;
   localparam logic [SPD_W-1:0] SPD_200 = 3'h1;
   localparam logic [SPD_W-1:0] SPD_400 = 3'h2;
   localparam logic [SPD_W-1:0] SPD_RST = 3'h0;
   localparam logic [EVT_W-1:0] EVT_RST = 5'h00;
   localparam logic [IRQ_W-1:0] STAT_RST = 8'h00;
   localparam logic [IRQ_W-1:0] MASK_RST = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [design/adcc_ctx.sv]
// Purpose: control and status of one async dma context
// Assumes: engine signals are on aclk
// Notes: set and clear writes never come in the same cycle
`timescale 1ns/1ps
module adcc_ctx
   import adcc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic soft_reset,
   input wire logic set_we,
   input wire logic clr_we,
   input wire logic [15:0] wbits,
   input wire logic fetch,
   input wire logic fatal,
   input wire logic active_in,
   input wire logic done,
   input wire logic [SPD_W-1:0] spd_in,
   input wire logic [EVT_W-1:0] evt_in,
   output logic [31:0] ctrl,
   output logic run,
   output logic wake,
   output logic start,
   output logic dead_ev
);
   logic run_q, run_d, wake_q, wake_d, dead_q, dead_d, act_q, act_d, start_q, start_d;
   logic [SPD_W-1:0] spd_q, spd_d;
   logic [EVT_W-1:0] evt_q, evt_d;

   always_comb begin
      run_d = run_q;
      if (set_we && wbits[RUN_BIT]) run_d = 1'b1; // R15 R2
      if (clr_we && wbits[RUN_BIT]) run_d = 1'b0; // R15 R3
      wake_d = wake_q;
      if (fetch) wake_d = 1'b0; // R5
      // software set wins over a fetch in the same cycle
      if (set_we && wbits[WAKE_BIT]) wake_d = 1'b1; // R4
      dead_d = (dead_q && !(run_q && !run_d)) || fatal; // R6 R7
      act_d = active_in; // R8
      spd_d = done ? spd_in : spd_q; // R9 R10
      evt_d = done ? evt_in : evt_q; // R11
      start_d = !run_q && run_d; // R14
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || soft_reset) begin // R3 R16
         run_q <= 1'b0;
         wake_q <= 1'b0;
         dead_q <= 1'b0;
         act_q <= 1'b0;
         start_q <= 1'b0;
         spd_q <= SPD_RST;
         evt_q <= EVT_RST;
      end else begin
         run_q <= run_d;
         wake_q <= wake_d;
         dead_q <= dead_d;
         act_q <= act_d;
         start_q <= start_d;
         spd_q <= spd_d;
         evt_q <= evt_d;
      end
   end

   always_comb begin
      ctrl = 32'h0000_0000; // R1
      ctrl[RUN_BIT] = run_q;
      ctrl[WAKE_BIT] = wake_q;
      ctrl[DEAD_BIT] = dead_q;
      ctrl[ACTIVE_BIT] = act_q;
      ctrl[SPD_LSB +: SPD_W] = spd_q;
      ctrl[EVT_LSB +: EVT_W] = evt_q;
   end
   assign run = run_q;
   assign wake = wake_q && run_q; // R4
   assign start = start_q;
   assign dead_ev = fatal && !dead_q;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence run_rise_s;
      !run && set_we && wbits[RUN_BIT] && !soft_reset;
   endsequence

   rsvd_zero_a: assert property (ctrl[31:16] == 16'h0 && ctrl[14:13] == 2'h0 && ctrl[9:8] == 2'h0) // R1
      else $error("reserved control bits not zero");
   run_hold_a: assert property (!set_we && !clr_we && !soft_reset |=> $stable(run)) // R3
      else $error("run changed without a write");
   soft_rst_a: assert property (soft_reset |=> !run && !ctrl[WAKE_BIT] && !ctrl[DEAD_BIT]) // R16
      else $error("soft reset left state set");
   wake_set_a: assert property (set_we && wbits[WAKE_BIT] && !soft_reset |=> ctrl[WAKE_BIT]) // R4
      else $error("wake not set by write");
   wake_fetch_a: assert property (fetch && !(set_we && wbits[WAKE_BIT]) |=> !ctrl[WAKE_BIT]) // R5
      else $error("wake not cleared on fetch");
   dead_set_a: assert property (fatal && !soft_reset |=> ctrl[DEAD_BIT]) // R6
      else $error("dead not set on fatal error");
   dead_keep_a: assert property (ctrl[DEAD_BIT] && !clr_we && !soft_reset |=> ctrl[DEAD_BIT]) // R7
      else $error("dead dropped while run kept");
   dead_clr_a: assert property (run && clr_we && wbits[RUN_BIT] && !fatal |=> !ctrl[DEAD_BIT]) // R7
      else $error("dead kept after run cleared");
   active_a: assert property (!soft_reset |=> ctrl[ACTIVE_BIT] == $past(active_in)) // R8
      else $error("active flag does not follow engine");
   evt_cap_a: assert property (done && !soft_reset |=> ctrl[4:0] == $past(evt_in) && ctrl[7:5] == $past(spd_in)) // R11
      else $error("completion fields not captured");
   start_a: assert property (run_rise_s |=> start ##1 !start) // R14
      else $error("start pulse missing after run set");
endmodule

// [design/adcc_top.sv]
// Purpose: axi4-lite bank for the four async dma context controls
// Assumes: engine inputs are on aclk, soft_reset is a synchronous level
// Notes: one write and one read in flight, irq is a level
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
module adcc_top
   import adcc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic soft_reset,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [NUM_CTX-1:0] eng_fetch,
   input wire logic [NUM_CTX-1:0] eng_fatal,
   input wire logic [NUM_CTX-1:0] eng_active,
   input wire logic [NUM_CTX-1:0] eng_done,
   input wire logic [NUM_CTX*SPD_W-1:0] eng_spd,
   input wire logic [NUM_CTX*EVT_W-1:0] eng_evt,
   output logic [NUM_CTX-1:0] ctx_run,
   output logic [NUM_CTX-1:0] ctx_wake,
   output logic [NUM_CTX-1:0] ctx_start,
   output logic irq
);
   localparam logic [ADDR_W-1:0] SET_OFS [NUM_CTX] = '{TXREQ_SET_OFS, TXRSP_SET_OFS,
      RXREQ_SET_OFS, RXRSP_SET_OFS};
   localparam logic [ADDR_W-1:0] CLR_OFS [NUM_CTX] = '{TXREQ_CLR_OFS, TXRSP_CLR_OFS,
      RXREQ_CLR_OFS, RXRSP_CLR_OFS};

   // write channel holding state
   logic aw_have_q, aw_have_d;
   logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
   logic w_have_q, w_have_d;
   logic [31:0] w_data_q, w_data_d;
   logic [3:0] w_strb_q, w_strb_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;

   // read channel state
   logic rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;

   // interrupt state
   logic [IRQ_W-1:0] stat_q, stat_d;
   logic [IRQ_W-1:0] mask_q, mask_d;

   logic wr_fire;
   logic wr_hit;
   logic [31:0] byte_mask;
   logic [31:0] wbits;
   logic [NUM_CTX-1:0] set_we;
   logic [NUM_CTX-1:0] clr_we;
   logic stat_we;
   logic mask_we;
   logic [31:0] ctrl_w [NUM_CTX];
   logic [NUM_CTX-1:0] dead_ev;
   logic [IRQ_W-1:0] irq_ev;
   logic rd_hit;
   logic [31:0] rd_word;

   assign s_axi_awready = !aw_have_q;
   assign s_axi_wready = !w_have_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // a write is applied once both halves are held and no response is pending
   assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
   assign byte_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
   assign wbits = w_data_q & byte_mask;

   // write decode, word aligned, low two address bits ignored
   always_comb begin
      set_we = '0;
      clr_we = '0;
      for (int i = 0; i < NUM_CTX; i++) begin
         set_we[i] = wr_fire && (aw_addr_q[ADDR_W-1:2] == SET_OFS[i][ADDR_W-1:2]); // R12 R13
         clr_we[i] = wr_fire && (aw_addr_q[ADDR_W-1:2] == CLR_OFS[i][ADDR_W-1:2]); // R12 R13
      end
      stat_we = wr_fire && (aw_addr_q[ADDR_W-1:2] == IRQ_STAT_OFS[ADDR_W-1:2]);
      mask_we = wr_fire && (aw_addr_q[ADDR_W-1:2] == IRQ_MASK_OFS[ADDR_W-1:2]);
      wr_hit = (|set_we) || (|clr_we) || stat_we || mask_we;
   end

   always_comb begin
      aw_have_d = aw_have_q;
      aw_addr_d = aw_addr_q;
      w_have_d = w_have_q;
      w_data_d = w_data_q;
      w_strb_d = w_strb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      if (s_axi_awvalid && !aw_have_q) begin
         aw_have_d = 1'b1;
         aw_addr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have_q) begin
         w_have_d = 1'b1;
         w_data_d = s_axi_wdata;
         w_strb_d = s_axi_wstrb;
      end
      if (wr_fire) begin
         aw_have_d = 1'b0;
         w_have_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         aw_addr_q <= '0;
         w_have_q <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else begin
         aw_have_q <= aw_have_d;
         aw_addr_q <= aw_addr_d;
         w_have_q <= w_have_d;
         w_data_q <= w_data_d;
         w_strb_q <= w_strb_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
      end
   end

   // read decode straight from the address channel
   always_comb begin
      rd_hit = 1'b0;
      rd_word = 32'h0000_0000;
      for (int i = 0; i < NUM_CTX; i++) begin
         if (s_axi_araddr[ADDR_W-1:2] == SET_OFS[i][ADDR_W-1:2] ||
             s_axi_araddr[ADDR_W-1:2] == CLR_OFS[i][ADDR_W-1:2]) begin
            rd_hit = 1'b1;
            rd_word = ctrl_w[i]; // R15 R1
         end
      end
      if (s_axi_araddr[ADDR_W-1:2] == IRQ_STAT_OFS[ADDR_W-1:2]) begin
         rd_hit = 1'b1;
         rd_word = {24'h00_0000, stat_q};
      end
      if (s_axi_araddr[ADDR_W-1:2] == IRQ_MASK_OFS[ADDR_W-1:2]) begin
         rd_hit = 1'b1;
         rd_word = {24'h00_0000, mask_q};
      end
   end

   always_comb begin
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (s_axi_arvalid && !rvalid_q) begin
         rvalid_d = 1'b1;
         rdata_d = rd_word;
         rresp_d = rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= RESP_OKAY;
      end else begin
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_CTX; g++) begin : g_ctx
         adcc_ctx u_ctx (
            .aclk(aclk),
            .aresetn(aresetn),
            .soft_reset(soft_reset),
            .set_we(set_we[g]),
            .clr_we(clr_we[g]),
            .wbits(wbits[15:0]),
            .fetch(eng_fetch[g]),
            .fatal(eng_fatal[g]),
            .active_in(eng_active[g]),
            .done(eng_done[g]),
            .spd_in(eng_spd[g*SPD_W +: SPD_W]),
            .evt_in(eng_evt[g*EVT_W +: EVT_W]),
            .ctrl(ctrl_w[g]),
            .run(ctx_run[g]),
            .wake(ctx_wake[g]),
            .start(ctx_start[g]),
            .dead_ev(dead_ev[g])
         );
      end
   endgenerate

   // low nibble: completion per context, high nibble: context went dead
   assign irq_ev = {dead_ev, eng_done};

   always_comb begin
      stat_d = stat_q;
      mask_d = mask_q;
      if (stat_we) stat_d = stat_q & ~wbits[IRQ_W-1:0];
      // new events win over a same-cycle write-one-to-clear
      stat_d = stat_d | irq_ev;
      if (mask_we) mask_d = (mask_q & ~byte_mask[IRQ_W-1:0]) | wbits[IRQ_W-1:0];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_q <= STAT_RST;
         mask_q <= MASK_RST;
      end else begin
         stat_q <= stat_d;
         mask_q <= mask_d;
      end
   end

   assign irq = |(stat_q & mask_q);

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence wr_taken_s;
      wr_fire;
   endsequence

   sequence resp_held_s;
      s_axi_bvalid && !s_axi_bready;
   endsequence

   bresp_time_a: assert property (wr_taken_s |=> s_axi_bvalid)
      else $error("write response not raised");
   bresp_hold_a: assert property (resp_held_s |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before bready");
   rresp_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed before rready");
   txreq_set_a: assert property (wr_fire && aw_addr_q == TXREQ_SET_OFS && wbits[RUN_BIT] && !soft_reset // R12
      |=> ctx_run[0])
      else $error("set address did not set run");
   rxreq_clr_a: assert property (wr_fire && aw_addr_q == RXREQ_CLR_OFS && wbits[RUN_BIT] // R13
      |=> !ctx_run[2])
      else $error("receive request clear address did not clear run");
   stat_sticky_a: assert property (|irq_ev |=> (stat_q & $past(irq_ev)) == $past(irq_ev))
      else $error("event lost in status register");
   irq_raise_a: assert property (|(irq_ev & mask_q) && !mask_we |=> irq)
      else $error("unmasked event did not raise irq");

   // every taken read or write gets its verdict one cycle later
   sequence rd_taken_s;
      s_axi_arvalid && s_axi_arready;
   endsequence

   sequence rd_miss_s;
      rd_taken_s ##0 !rd_hit;
   endsequence

   rvalid_time_a: assert property (rd_taken_s |=> s_axi_rvalid)
      else $error("read data not returned");
   rd_miss_a: assert property (rd_miss_s |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
      else $error("unmapped read not refused");
   rd_hit_a: assert property (rd_taken_s ##0 rd_hit // R1
      |=> s_axi_rresp == RESP_OKAY && s_axi_rdata[31:16] == 16'h0000)
      else $error("mapped read refused or upper half set");
   wr_miss_a: assert property (wr_taken_s ##0 !wr_hit |=> s_axi_bresp == RESP_SLVERR)
      else $error("unmapped write not refused");
   wr_hit_a: assert property (wr_taken_s ##0 wr_hit |=> s_axi_bresp == RESP_OKAY) // R12
      else $error("mapped write refused");

   // a taken half blocks its channel until the write is applied
   aw_block_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("address channel open while an address is held");
   w_block_a: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
      else $error("data channel open while data is held");
   bvalid_ack_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   rvalid_ack_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data repeated");

   // only checked where no event lands in the same cycle, since set wins
   stat_clr_a: assert property (stat_we && wbits[0] && !irq_ev[0] |=> !stat_q[0])
      else $error("status bit not cleared by write of one");
   mask_wr_a: assert property (mask_we && w_strb_q[0] && wbits[4] |=> mask_q[4])
      else $error("mask bit not written");

   // per-context map and engine checks
   genvar m;
   generate
      for (m = 0; m < NUM_CTX; m++) begin : g_ctx_chk
         // run set and clear as decoded from the held address
         sequence set_run_s;
            wr_fire && aw_addr_q == SET_OFS[m] && wbits[RUN_BIT] && !soft_reset;
         endsequence

         sequence clr_run_s;
            wr_fire && aw_addr_q == CLR_OFS[m] && wbits[RUN_BIT];
         endsequence

         set_map_a: assert property (set_run_s |=> ctx_run[m]) // R12 R13
            else $error("set address did not set run");
         clr_map_a: assert property (clr_run_s |=> !ctx_run[m]) // R12 R13
            else $error("clear address did not clear run");
         wake_out_a: assert property (set_run_s ##0 wbits[WAKE_BIT] |=> ctx_wake[m]) // R4
            else $error("wake not passed to the engine");

         // engine side of the same context
         fetch_wake_a: assert property (eng_fetch[m] && !set_we[m] |=> !ctx_wake[m]) // R5
            else $error("wake still shown after fetch");
         start_once_a: assert property (ctx_start[m] |=> !ctx_start[m]) // R14
            else $error("start pulse longer than one cycle");
         act_map_a: assert property (eng_active[m] && !soft_reset |=> ctrl_w[m][ACTIVE_BIT]) // R8
            else $error("active flag not shown");
         done_irq_a: assert property (eng_done[m] |=> stat_q[m]) // R11
            else $error("completion not flagged");
         dead_irq_a: assert property (eng_fatal[m] && !ctrl_w[m][DEAD_BIT] |=> stat_q[NUM_CTX+m]) // R6
            else $error("dead event not flagged");
      end
   endgenerate
endmodule

// [sim/test_async_dma_context_control.sv]
// Purpose: self-checking bench for the async dma context control bank
// Assumes: ready outputs come from registers, so the bus tasks sample handshakes at the falling edge
// Notes: speed and event codes are random within legal codes
`timescale 1ns/1ps
module test_async_dma_context_control;
   import adcc_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic soft_reset = 1'b0;
   logic [ADDR_W-1:0] s_axi_awaddr = '0;
   logic [ADDR_W-1:0] s_axi_araddr = '0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [NUM_CTX-1:0] eng_fetch = '0, eng_fatal = '0, eng_active = '0, eng_done = '0;
   logic [NUM_CTX*SPD_W-1:0] eng_spd = '0;
   logic [NUM_CTX*EVT_W-1:0] eng_evt = '0;
   logic [NUM_CTX-1:0] ctx_run, ctx_wake, ctx_start;
   logic [NUM_CTX-1:0] run_m = '0, wake_m = '0, dead_m = '0, act_m = '0;
   logic [SPD_W-1:0] spd_m [NUM_CTX] = '{default: '0};
   logic [EVT_W-1:0] evt_m [NUM_CTX] = '{default: '0};
   logic [7:0] stat_m = '0, mask_m = '0;
   logic [ADDR_W-1:0] set_a [NUM_CTX] = '{TXREQ_SET_OFS, TXRSP_SET_OFS, RXREQ_SET_OFS, RXRSP_SET_OFS};
   logic [ADDR_W-1:0] clr_a [NUM_CTX] = '{TXREQ_CLR_OFS, TXRSP_CLR_OFS, RXREQ_CLR_OFS, RXRSP_CLR_OFS};
   int starts [NUM_CTX] = '{default: 0};
   int start_m [NUM_CTX] = '{default: 0};
   int num_errors = 0;
   int total_checks = 0;
   int cyc = 0;
   int seed = 32'h3dcb;

   adcc_top dut_u (.aclk(aclk), .aresetn(aresetn), .soft_reset(soft_reset),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .eng_fetch(eng_fetch),
      .eng_fatal(eng_fatal), .eng_active(eng_active), .eng_done(eng_done), .eng_spd(eng_spd),
      .eng_evt(eng_evt), .ctx_run(ctx_run), .ctx_wake(ctx_wake), .ctx_start(ctx_start), .irq(irq));

   always #2.5 aclk = ~aclk;

   // start pulses last one cycle, so they are counted away from the rising edge
   always @(negedge aclk) begin
      for (int k = 0; k < NUM_CTX; k++) begin
         if (ctx_start[k] === 1'b1) begin
            starts[k]++;
         end
      end
   end

   always @(posedge aclk) begin
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         results();
      end
   end

   task automatic results;
      if (num_errors == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic logic [31:0] exp_ctrl(input int i);
      return {16'h0000, run_m[i], 2'b00, wake_m[i], dead_m[i], act_m[i], 2'b00, spd_m[i], evt_m[i]};
   endfunction

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] dv, output logic [1:0] r);
      logic aw_t, w_t, b_t, fin;
      fin = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= dv;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!fin) begin
         @(negedge aclk);
         aw_t = s_axi_awvalid && s_axi_awready;
         w_t = s_axi_wvalid && s_axi_wready;
         b_t = s_axi_bvalid && s_axi_bready;
         r = s_axi_bresp;
         @(posedge aclk);
         if (aw_t) s_axi_awvalid <= 1'b0;
         if (w_t) s_axi_wvalid <= 1'b0;
         if (b_t) begin
            s_axi_bready <= 1'b0;
            fin = 1'b1;
         end
      end
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar_t, r_t, fin;
      fin = 1'b0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!fin) begin
         @(negedge aclk);
         ar_t = s_axi_arvalid && s_axi_arready;
         r_t = s_axi_rvalid && s_axi_rready;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         if (ar_t) s_axi_arvalid <= 1'b0;
         if (r_t) begin
            s_axi_rready <= 1'b0;
            fin = 1'b1;
         end
      end
   endtask

   task automatic check_ctx(input int i);
      logic [31:0] d;
      logic [1:0] r;
      rd(set_a[i], d, r);
      chk(d, exp_ctrl(i));
      chk(32'(r), 32'(RESP_OKAY));
      rd(clr_a[i], d, r);
      chk(d, exp_ctrl(i));
      chk(32'(ctx_run[i]), 32'(run_m[i]));
      chk(32'(ctx_wake[i]), 32'(run_m[i] & wake_m[i]));
      chk(32'(irq), 32'(|(stat_m & mask_m)));
   endtask

   // kind 0 fetch, 1 fatal, 2 done with random legal speed and event
   task automatic eng(input int k, input int i);
      logic [NUM_CTX-1:0] oh;
      oh = NUM_CTX'(1) << i;
      @(posedge aclk);
      case (k)
         0: eng_fetch <= oh;
         1: eng_fatal <= oh;
         default: begin
            spd_m[i] = SPD_W'($unsigned($random(seed)) % 3);
            evt_m[i] = EVT_W'($random(seed));
            eng_spd[SPD_W*i +: SPD_W] <= spd_m[i];
            eng_evt[EVT_W*i +: EVT_W] <= evt_m[i];
            eng_done <= oh;
         end
      endcase
      @(posedge aclk);
      eng_fetch <= '0;
      eng_fatal <= '0;
      eng_done <= '0;
   endtask

   initial begin
      logic [31:0] d;
      logic [1:0] r;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < NUM_CTX; i++) begin
         check_ctx(i);
      end
      for (int i = 0; i < NUM_CTX; i++) begin
         wr(set_a[i], 32'hffffffff, r);
         chk(32'(r), 32'(RESP_OKAY));
         run_m[i] = 1'b1;
         wake_m[i] = 1'b1;
         start_m[i]++;
         check_ctx(i);
         chk(starts[i], start_m[i]);
         eng(0, i);
         wake_m[i] = 1'b0;
         check_ctx(i);
         @(posedge aclk);
         eng_active[i] <= 1'b1;
         act_m[i] = 1'b1;
         check_ctx(i);
         eng_active[i] <= 1'b0;
         act_m[i] = 1'b0;
         eng(2, i);
         stat_m[i] = 1'b1;
         check_ctx(i);
         eng(1, i);
         dead_m[i] = 1'b1;
         stat_m[4+i] = 1'b1;
         check_ctx(i);
         // clear word without the run bit must leave dead standing
         wr(clr_a[i], $random(seed) & 32'hffff7fff, r);
         check_ctx(i);
         wr(clr_a[i], 32'h00008000, r);
         run_m[i] = 1'b0;
         dead_m[i] = 1'b0;
         check_ctx(i);
      end
      rd(IRQ_STAT_OFS, d, r);
      chk(d, {24'h0, stat_m});
      wr(IRQ_MASK_OFS, 32'h00000010, r);
      mask_m = 8'h10;
      check_ctx(0);
      wr(IRQ_STAT_OFS, 32'h000000ff, r);
      stat_m = 8'h00;
      check_ctx(0);
      // a fresh dead event while its mask bit is open must raise irq
      eng(1, 0);
      dead_m[0] = 1'b1;
      stat_m[4] = 1'b1;
      check_ctx(0);
      wr(9'h100, $random(seed), r);
      chk(32'(r), 32'(RESP_SLVERR));
      rd(9'h100, d, r);
      chk(d, 32'h00000000);
      chk(32'(r), 32'(RESP_SLVERR));
      // run and wake sit in byte one, so a low-byte-only strobe leaves them alone
      s_axi_wstrb <= 4'h1;
      wr(set_a[0], 32'h00009000, r);
      s_axi_wstrb <= 4'hf;
      chk(32'(r), 32'(RESP_OKAY));
      check_ctx(0);
      for (int i = 0; i < NUM_CTX; i++) begin
         wr(set_a[i], 32'h00009000, r);
         run_m[i] = 1'b1;
         wake_m[i] = 1'b1;
         start_m[i]++;
         check_ctx(i);
         chk(starts[i], start_m[i]);
      end
      @(posedge aclk);
      soft_reset <= 1'b1;
      @(posedge aclk);
      soft_reset <= 1'b0;
      run_m = '0;
      wake_m = '0;
      dead_m = '0;
      // soft reset also zeroes the latched speed and event fields
      for (int i = 0; i < NUM_CTX; i++) begin
         spd_m[i] = '0;
         evt_m[i] = '0;
         check_ctx(i);
      end
      results();
   end
endmodule
